/* core/drive_supervisor.sv */
// Behaviour
// - Qualifying trip with retry enabled: clear and restart alone, alarm stays low.
// - Trips beyond the retry limit raise the alarm and stop further retries.
// - Retry limit accepts 0 (off) or 1 to 10 attempts.
// - Wait the retry interval, 0.5 to 20.0 s, before the internal reset.
// - Only overcurrent, overvoltage, overheats, overloads qualify for retry.
// - Retry-in-progress output is high while retrying.
// - Fan control on: fan stops only when stopped and cool; runs at least 10 min.
// - Fan select 0 keeps fan running, 1 allows on/off control.
// - Fan-running output is high while the fan runs with fan select 1; with fan select 0 it stays low.
// - Direction lock: 0 none, 1 no reverse, 2 no forward.
// - Force low: mode 0 never, 1 power-loss restart only, 2 both; power-loss restarts search only with restart mode 3 to 5.
// - Force high: search on normal start, and on power-loss restart when restart mode is 3 to 5.
// - An unassigned force input reads as low.
// - V/f control uses the first mode, sensored vector control the second.
// - Search lasts at most 1.2 s, then acceleration starts.
// - Run-command start delays the search by the first delay.
// - Power-loss restart, coast-stop release or retry wait the second delay.
`timescale 1ns/10ps
module drive_supervisor #(
	parameter int TICK_CYCLES = drive_sup_pkg::TICK_CYCLES_DEFAULT
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic trip_i,
	input wire logic [3:0] trip_cause_i,
	input wire logic run_start_i,
	input wire logic power_restart_i,
	input wire logic stop_i,
	input wire logic search_done_i,
	input wire logic drive_running_i,
	input wire logic temp_low_i,
	input wire logic fwd_cmd_i,
	input wire logic rev_cmd_i,
	input wire logic coast_stop_in_i,
	input wire logic search_force_in_i,
	output logic alarm_out_o,
	output logic retry_active_out_o,
	output logic trip_reset_o,
	output logic fan_on_o,
	output logic fan_running_out_o,
	output logic fwd_run_o,
	output logic rev_run_o,
	output logic search_active_o,
	output logic accel_start_o
);
	// ****************************************************************
	// Settings and bus slave
	// ****************************************************************
	logic [3:0] retry_limit_setting;
	logic fan_control_select;
	logic [1:0] direction_lock_select;
	logic force_assigned;
	logic [2:0] drive_control_select;
	logic [1:0] search_mode_vf;
	logic [1:0] search_mode_vector;
	logic [2:0] power_loss_restart_mode;
	logic [7:0] retry_interval_setting;
	logic [7:0] search_delay_first;
	logic [7:0] search_delay_second;
	logic [31:0] ctrl_word;
	logic [31:0] time_word;
	logic [31:0] status_word;
	logic [31:0] ctrl_new;
	logic [31:0] time_new;
	logic bus_req;
	logic wr_take;
	logic clear_alarm;
	logic [3:0] retry_count;
	drive_sup_pkg::retry_state_e retry_state;
	drive_sup_pkg::start_state_e start_state;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_take = bus_req && wb_we_i;
	assign clear_alarm = wr_take && wb_adr_i == drive_sup_pkg::ADR_CMD && wb_sel_i[0]
		&& wb_dat_i[drive_sup_pkg::CMD_CLEAR_ALARM_BIT];

	assign ctrl_word = {14'h0000, power_loss_restart_mode, search_mode_vector, search_mode_vf,
		drive_control_select, force_assigned, direction_lock_select, fan_control_select,
		retry_limit_setting};
	assign time_word = {8'h00, search_delay_second, search_delay_first, retry_interval_setting};
	assign status_word = {20'h00000, retry_count, retry_state, start_state, fan_on_o, search_active_o,
		retry_active_out_o, alarm_out_o};

	always_comb begin
		for (int b = 0; b < 4; b++) begin
			ctrl_new[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : ctrl_word[8*b +: 8];
			time_new[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : time_word[8*b +: 8];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			unique case (wb_adr_i)
				drive_sup_pkg::ADR_CTRL: wb_dat_o <= ctrl_word;
				drive_sup_pkg::ADR_TIME: wb_dat_o <= time_word;
				drive_sup_pkg::ADR_STATUS: wb_dat_o <= status_word;
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// Out-of-range retry limit and TIME writes are clamped; the other CTRL fields are stored as written.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			retry_limit_setting <= drive_sup_pkg::RST_RETRY_LIMIT;
			fan_control_select <= drive_sup_pkg::RST_FAN_SELECT;
			direction_lock_select <= drive_sup_pkg::RST_DIR_LOCK;
			force_assigned <= 1'b0;
			drive_control_select <= drive_sup_pkg::RST_CONTROL;
			search_mode_vf <= drive_sup_pkg::RST_MODE_VF;
			search_mode_vector <= drive_sup_pkg::RST_MODE_VEC;
			power_loss_restart_mode <= drive_sup_pkg::RST_PLR_MODE;
		end else if (wr_take && wb_adr_i == drive_sup_pkg::ADR_CTRL) begin
			retry_limit_setting <= (ctrl_new[drive_sup_pkg::CTRL_LIMIT_LSB +: 4] > drive_sup_pkg::RETRY_LIMIT_MAX)
				? drive_sup_pkg::RETRY_LIMIT_MAX : ctrl_new[drive_sup_pkg::CTRL_LIMIT_LSB +: 4];
			fan_control_select <= ctrl_new[drive_sup_pkg::CTRL_FAN_BIT];
			direction_lock_select <= ctrl_new[drive_sup_pkg::CTRL_DIR_LSB +: 2];
			force_assigned <= ctrl_new[drive_sup_pkg::CTRL_FORCE_ASSIGNED_BIT];
			drive_control_select <= ctrl_new[drive_sup_pkg::CTRL_CONTROL_LSB +: 3];
			search_mode_vf <= ctrl_new[drive_sup_pkg::CTRL_MODE_VF_LSB +: 2];
			search_mode_vector <= ctrl_new[drive_sup_pkg::CTRL_MODE_VEC_LSB +: 2];
			power_loss_restart_mode <= ctrl_new[drive_sup_pkg::CTRL_PLR_LSB +: 3];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			retry_interval_setting <= drive_sup_pkg::RST_INTERVAL;
			search_delay_first <= drive_sup_pkg::RST_DELAY1;
			search_delay_second <= drive_sup_pkg::RST_DELAY2;
		end else if (wr_take && wb_adr_i == drive_sup_pkg::ADR_TIME) begin
			if (time_new[drive_sup_pkg::TIME_INTERVAL_LSB +: 8] < drive_sup_pkg::INTERVAL_MIN) begin
				retry_interval_setting <= drive_sup_pkg::INTERVAL_MIN;
			end else if (time_new[drive_sup_pkg::TIME_INTERVAL_LSB +: 8] > drive_sup_pkg::INTERVAL_MAX) begin
				retry_interval_setting <= drive_sup_pkg::INTERVAL_MAX;
			end else begin
				retry_interval_setting <= time_new[drive_sup_pkg::TIME_INTERVAL_LSB +: 8];
			end
			search_delay_first <= (time_new[drive_sup_pkg::TIME_DELAY1_LSB +: 8] > drive_sup_pkg::DELAY1_MAX)
				? drive_sup_pkg::DELAY1_MAX : time_new[drive_sup_pkg::TIME_DELAY1_LSB +: 8];
			if (time_new[drive_sup_pkg::TIME_DELAY2_LSB +: 8] < drive_sup_pkg::DELAY2_MIN) begin
				search_delay_second <= drive_sup_pkg::DELAY2_MIN;
			end else if (time_new[drive_sup_pkg::TIME_DELAY2_LSB +: 8] > drive_sup_pkg::DELAY2_MAX) begin
				search_delay_second <= drive_sup_pkg::DELAY2_MAX;
			end else begin
				search_delay_second <= time_new[drive_sup_pkg::TIME_DELAY2_LSB +: 8];
			end
		end
	end

	// ****************************************************************
	// Time base and pin synchronisers
	// ****************************************************************
	logic [31:0] prescale;
	logic tick;
	logic [1:0] coast_sync;
	logic [1:0] force_sync;
	logic coast_prev;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			prescale <= 32'h00000000;
			tick <= 1'b0;
		end else if (prescale == 32'(TICK_CYCLES - 1)) begin
			prescale <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			prescale <= prescale + 32'h00000001;
			tick <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			coast_sync <= 2'b00;
			force_sync <= 2'b00;
			coast_prev <= 1'b0;
		end else begin
			coast_sync <= {coast_sync[0], coast_stop_in_i};
			force_sync <= {force_sync[0], search_force_in_i};
			coast_prev <= coast_sync[1];
		end
	end

	tenth_timer_if #(.W(drive_sup_pkg::TIMER_W)) retry_tmr ();
	tenth_timer_if #(.W(drive_sup_pkg::TIMER_W)) seq_tmr ();
	tenth_timer_if #(.W(drive_sup_pkg::TIMER_W)) fan_tmr ();

	tenth_timer #(.W(drive_sup_pkg::TIMER_W)) u_retry_tmr (.mclk_i(mclk_i), .srst_i(srst_i), .tick_i(tick), .t(retry_tmr));
	tenth_timer #(.W(drive_sup_pkg::TIMER_W)) u_seq_tmr (.mclk_i(mclk_i), .srst_i(srst_i), .tick_i(tick), .t(seq_tmr));
	tenth_timer #(.W(drive_sup_pkg::TIMER_W)) u_fan_tmr (.mclk_i(mclk_i), .srst_i(srst_i), .tick_i(tick), .t(fan_tmr));

	// ****************************************************************
	// Automatic retry after a trip
	// ****************************************************************
	logic qualifies;
	logic may_retry;
	logic trip_seen;

	assign qualifies = trip_cause_i >= drive_sup_pkg::CAUSE_RETRY_FIRST
		&& trip_cause_i <= drive_sup_pkg::CAUSE_RETRY_LAST;
	assign may_retry = qualifies && retry_limit_setting != 4'h0 && retry_count < retry_limit_setting;
	assign trip_seen = trip_i && (retry_state == drive_sup_pkg::RT_NORMAL || retry_state == drive_sup_pkg::RT_RESTART);
	assign retry_tmr.load = trip_seen && may_retry;
	assign retry_tmr.value = drive_sup_pkg::TIMER_W'(retry_interval_setting);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			retry_state <= drive_sup_pkg::RT_NORMAL;
			retry_count <= 4'h0;
			trip_reset_o <= 1'b0;
		end else begin
			trip_reset_o <= 1'b0;
			unique case (retry_state)
				drive_sup_pkg::RT_NORMAL, drive_sup_pkg::RT_RESTART: begin
					if (trip_seen && may_retry) begin
						retry_state <= drive_sup_pkg::RT_WAIT;
						retry_count <= retry_count + 4'h1;
					end else if (trip_seen) begin
						retry_state <= drive_sup_pkg::RT_ALARM;
					end else if (retry_state == drive_sup_pkg::RT_RESTART && drive_running_i) begin
						retry_state <= drive_sup_pkg::RT_NORMAL;
						retry_count <= 4'h0;
					end
				end
				drive_sup_pkg::RT_WAIT: begin
					if (retry_tmr.done) begin
						trip_reset_o <= 1'b1;
						retry_state <= drive_sup_pkg::RT_RESTART;
					end
				end
				drive_sup_pkg::RT_ALARM: begin
					if (clear_alarm) begin
						retry_state <= drive_sup_pkg::RT_NORMAL;
						retry_count <= 4'h0;
					end
				end
			endcase
		end
	end

	// Retry is "in progress" from the trip until normal running resumes.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			alarm_out_o <= 1'b0;
			retry_active_out_o <= 1'b0;
		end else begin
			alarm_out_o <= retry_state == drive_sup_pkg::RT_ALARM;
			retry_active_out_o <= retry_state == drive_sup_pkg::RT_WAIT
				|| retry_state == drive_sup_pkg::RT_RESTART;
		end
	end

	// ****************************************************************
	// Start sequencing and speed search
	// ****************************************************************
	logic force_level;
	logic [1:0] mode_now;
	logic search_on_restart;
	logic search_on_start;
	logic second_req;
	logic first_req;
	logic search_pending;

	assign force_level = force_assigned && force_sync[1];
	assign mode_now = (drive_control_select == drive_sup_pkg::CONTROL_VECTOR_SENSOR)
		? search_mode_vector : search_mode_vf;
	assign search_on_restart = force_level || mode_now == drive_sup_pkg::MODE_POWER_LOSS
		|| mode_now == drive_sup_pkg::MODE_BOTH;
	assign search_on_start = force_level || mode_now == drive_sup_pkg::MODE_BOTH;
	assign second_req = power_restart_i || (coast_prev && !coast_sync[1]) || trip_reset_o;
	assign first_req = run_start_i && !second_req;
	assign seq_tmr.load = (start_state == drive_sup_pkg::ST_IDLE && (first_req || second_req))
		|| (start_state == drive_sup_pkg::ST_DELAY && seq_tmr.done && search_pending);
	assign seq_tmr.value = (start_state == drive_sup_pkg::ST_DELAY) ? drive_sup_pkg::SEARCH_LIMIT_TENTHS
		: second_req ? drive_sup_pkg::TIMER_W'(search_delay_second)
		: search_on_start ? drive_sup_pkg::TIMER_W'(search_delay_first) : drive_sup_pkg::TIMER_W'(0);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			start_state <= drive_sup_pkg::ST_IDLE;
			search_pending <= 1'b0;
			search_active_o <= 1'b0;
			accel_start_o <= 1'b0;
		end else begin
			accel_start_o <= 1'b0;
			if (trip_i || stop_i) begin
				start_state <= drive_sup_pkg::ST_IDLE;
				search_active_o <= 1'b0;
			end else begin
				unique case (start_state)
					drive_sup_pkg::ST_IDLE: begin
						if (second_req) begin
							start_state <= drive_sup_pkg::ST_DELAY;
							search_pending <= power_restart_i
								? (search_on_restart && power_loss_restart_mode >= drive_sup_pkg::PLR_SEARCH_MIN
								&& power_loss_restart_mode <= drive_sup_pkg::PLR_SEARCH_MAX)
								: search_on_start;
						end else if (first_req) begin
							start_state <= drive_sup_pkg::ST_DELAY;
							search_pending <= search_on_start;
						end
					end
					drive_sup_pkg::ST_DELAY: begin
						if (seq_tmr.done && search_pending) begin
							start_state <= drive_sup_pkg::ST_SEARCH;
							search_active_o <= 1'b1;
						end else if (seq_tmr.done) begin
							start_state <= drive_sup_pkg::ST_RUN;
							accel_start_o <= 1'b1;
						end
					end
					drive_sup_pkg::ST_SEARCH: begin
						if (search_done_i || seq_tmr.done) begin
							start_state <= drive_sup_pkg::ST_RUN;
							search_active_o <= 1'b0;
							accel_start_o <= 1'b1;
						end
					end
					drive_sup_pkg::ST_RUN: begin
						start_state <= drive_sup_pkg::ST_RUN;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Direction lock
	// ****************************************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fwd_run_o <= 1'b0;
			rev_run_o <= 1'b0;
		end else begin
			fwd_run_o <= fwd_cmd_i && direction_lock_select != drive_sup_pkg::DIR_NO_FORWARD;
			rev_run_o <= rev_cmd_i && direction_lock_select != drive_sup_pkg::DIR_NO_REVERSE;
		end
	end

	// ****************************************************************
	// Cooling fan
	// ****************************************************************
	// The minimum run time protects the fan from wear caused by rapid cycling.
	logic fan_want;

	assign fan_want = !fan_control_select || drive_running_i || !temp_low_i;
	assign fan_tmr.load = fan_want && !fan_on_o;
	assign fan_tmr.value = drive_sup_pkg::FAN_MIN_TENTHS;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			fan_on_o <= 1'b0;
			fan_running_out_o <= 1'b0;
		end else begin
			if (fan_want) begin
				fan_on_o <= 1'b1;
			end else if (fan_tmr.done) begin
				fan_on_o <= 1'b0;
			end
			fan_running_out_o <= fan_control_select && (fan_want || (fan_on_o && !fan_tmr.done));
		end
	end
endmodule : drive_supervisor

/* core/drive_sup_pkg.sv */
package drive_sup_pkg;

	// ****************************************************************
	// Register map (byte addresses on the bus)
	// ****************************************************************
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_TIME = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_CMD = 8'h0c;

	// CTRL fields.
	localparam int CTRL_LIMIT_LSB = 0;
	localparam int CTRL_FAN_BIT = 4;
	localparam int CTRL_DIR_LSB = 5;
	localparam int CTRL_FORCE_ASSIGNED_BIT = 7;
	localparam int CTRL_CONTROL_LSB = 8;
	localparam int CTRL_MODE_VF_LSB = 11;
	localparam int CTRL_MODE_VEC_LSB = 13;
	localparam int CTRL_PLR_LSB = 15;
	// TIME fields, all in tenths of a second.
	localparam int TIME_INTERVAL_LSB = 0;
	localparam int TIME_DELAY1_LSB = 8;
	localparam int TIME_DELAY2_LSB = 16;
	// CMD fields.
	localparam int CMD_CLEAR_ALARM_BIT = 0;

	// Reset values.
	localparam logic [3:0] RST_RETRY_LIMIT = 4'h0;
	localparam logic RST_FAN_SELECT = 1'b0;
	localparam logic [1:0] RST_DIR_LOCK = 2'h0;
	localparam logic [2:0] RST_CONTROL = 3'h0;
	localparam logic [1:0] RST_MODE_VF = 2'h0;
	localparam logic [1:0] RST_MODE_VEC = 2'h2;
	localparam logic [2:0] RST_PLR_MODE = 3'h0;
	localparam logic [7:0] RST_INTERVAL = 8'h05;
	localparam logic [7:0] RST_DELAY1 = 8'h00;
	localparam logic [7:0] RST_DELAY2 = 8'h01;

	// Setting ranges.
	localparam logic [3:0] RETRY_LIMIT_MAX = 4'ha;
	localparam logic [7:0] INTERVAL_MIN = 8'h05;
	localparam logic [7:0] INTERVAL_MAX = 8'hc8;
	localparam logic [7:0] DELAY1_MAX = 8'h64;
	localparam logic [7:0] DELAY2_MIN = 8'h01;
	localparam logic [7:0] DELAY2_MAX = 8'h64;

	// Encodings.
	localparam logic [1:0] DIR_NO_REVERSE = 2'h1;
	localparam logic [1:0] DIR_NO_FORWARD = 2'h2;
	localparam logic [1:0] MODE_POWER_LOSS = 2'h1;
	localparam logic [1:0] MODE_BOTH = 2'h2;
	localparam logic [2:0] CONTROL_VF_MAX = 3'h2;
	localparam logic [2:0] CONTROL_VECTOR_SENSOR = 3'h5;
	localparam logic [2:0] PLR_SEARCH_MIN = 3'h3;
	localparam logic [2:0] PLR_SEARCH_MAX = 3'h5;
	localparam logic [3:0] CAUSE_RETRY_FIRST = 4'h1;
	localparam logic [3:0] CAUSE_RETRY_LAST = 4'h8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam longint CLK_PERIOD_PS = 10000;
	localparam longint TENTH_S_PS = 64'd100000000000;
	localparam int TICK_CYCLES_DEFAULT = int'(TENTH_S_PS / CLK_PERIOD_PS);
	localparam int TIMER_W = 13;
	localparam real SEARCH_LIMIT_S = 1.2;
	localparam real FAN_MIN_RUN_MIN = 10.0;
	localparam logic [12:0] SEARCH_LIMIT_TENTHS = 13'(int'(SEARCH_LIMIT_S * 10.0));
	localparam logic [12:0] FAN_MIN_TENTHS = 13'(int'(FAN_MIN_RUN_MIN * 600.0));

	typedef enum logic [1:0] {
		RT_NORMAL = 2'b00,
		RT_WAIT = 2'b01,
		RT_RESTART = 2'b11,
		RT_ALARM = 2'b10
	} retry_state_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_SEARCH = 2'b11,
		ST_RUN = 2'b10
	} start_state_e;

endpackage : drive_sup_pkg

/* core/tenth_timer_if.sv */
`timescale 1ns/10ps
interface tenth_timer_if #(
	parameter int W = 13
);
	logic load;
	logic [W-1:0] value;
	logic done;

	modport owner (output load, output value, input done);
	modport timer (input load, input value, output done);
endinterface : tenth_timer_if

/* core/tenth_timer.sv */
`timescale 1ns/10ps
module tenth_timer #(
	parameter int W = 13
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic tick_i,
	tenth_timer_if.timer t
);
	logic [W-1:0] count;

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			count <= '0;
		end else if (t.load) begin
			count <= t.value;
		end else if (tick_i && count != '0) begin
			count <= count - W'(1);
		end
	end

	assign t.done = (count == '0);
endmodule : tenth_timer

/* test/drive_sup_asserts.sv */
`timescale 1ns/10ps
// ********************************
// Supervisor property checker
// ********************************
module drive_sup_asserts #(
	parameter int TICK_CYCLES = 10
) (
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic fwd_cmd_i,
	input wire logic rev_cmd_i,
	input wire logic alarm_out_o,
	input wire logic retry_active_out_o,
	input wire logic trip_reset_o,
	input wire logic fan_on_o,
	input wire logic fan_running_out_o,
	input wire logic fwd_run_o,
	input wire logic rev_run_o,
	input wire logic search_active_o
);
	localparam int SLIM = 13 * TICK_CYCLES + 4;
	localparam int FMIN = 5999 * TICK_CYCLES;
	int srch_n;
	int fan_n;
	// Long runs are counted here, since a repetition that long cannot be unrolled.
	always_ff @(posedge mclk_i) begin
		srch_n <= (srst_i || !search_active_o) ? 0 : srch_n + 1;
	end
	always_ff @(posedge mclk_i) begin
		fan_n <= (srst_i || !fan_on_o) ? 0 : fan_n + 1;
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	reset_retry_a: assert property (trip_reset_o |-> retry_active_out_o && !alarm_out_o)
		else $error("reset command outside a retry");
	alarm_blocks_a: assert property (alarm_out_o |-> !trip_reset_o)
		else $error("reset command while alarm is up");
	interval_floor_a: assert property ($rose(retry_active_out_o) |-> !trip_reset_o [*8])
		else $error("reset command too early");
	fan_flag_a: assert property (fan_running_out_o |-> fan_on_o || $past(fan_on_o))
		else $error("fan flag without fan");
	fwd_gate_a: assert property (fwd_run_o |-> $past(fwd_cmd_i))
		else $error("forward run without command");
	rev_gate_a: assert property (rev_run_o |-> $past(rev_cmd_i))
		else $error("reverse run without command");
	search_limit_a: assert property (srch_n <= SLIM)
		else $error("search runs too long");
	fan_hold_a: assert property ($fell(fan_on_o) |-> fan_n >= FMIN)
		else $error("fan stopped before minimum run");
endmodule : drive_sup_asserts

/* test/tb.sv */
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
	$display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb;
	localparam int TK = 10;
	localparam logic [7:0] A_CT = drive_sup_pkg::ADR_CTRL, A_TM = drive_sup_pkg::ADR_TIME;
	logic mclk_i = 1'h0, srst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0, trip_cause_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic trip_i = 1'h0, run_start_i = 1'h0, power_restart_i = 1'h0, stop_i = 1'h0, search_done_i = 1'h0;
	logic drive_running_i = 1'h0, temp_low_i = 1'h0, fwd_cmd_i = 1'h0, rev_cmd_i = 1'h0;
	logic coast_stop_in_i = 1'h0, search_force_in_i = 1'h0;
	logic wb_ack_o, alarm_out_o, retry_active_out_o, trip_reset_o, fan_on_o, fan_running_out_o;
	logic fwd_run_o, rev_run_o, search_active_o, accel_start_o;
	logic [15:0] rnd = 16'h6e45;
	logic [2:0] s;
	logic [1:0] mv, mc;
	int err_total = 0, compares = 0, iv, lim, p, n, at, len, dl;
	drive_supervisor #(.TICK_CYCLES(TK)) drive_supervisor_i (.mclk_i, .srst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .trip_i, .trip_cause_i,
		.run_start_i, .power_restart_i, .stop_i, .search_done_i, .drive_running_i, .temp_low_i,
		.fwd_cmd_i, .rev_cmd_i, .coast_stop_in_i, .search_force_in_i, .alarm_out_o, .retry_active_out_o,
		.trip_reset_o, .fan_on_o, .fan_running_out_o, .fwd_run_o, .rev_run_o, .search_active_o,
		.accel_start_o);
	// ****************
	// Helpers
	// ****************
	function automatic int roll(input int m);
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return int'(rnd) % m;
	endfunction : roll
	function automatic logic [31:0] ctrl(input logic [3:0] l, input logic f, input logic [1:0] d,
		input logic a, input logic [2:0] c, input logic [1:0] v, input logic [1:0] w);
		return {14'h0, 3'h3, w, v, c, a, d, f, l};
	endfunction : ctrl
	function automatic logic want(input logic [2:0] c, input logic [1:0] v, input logic [1:0] w,
		input logic frc, input logic pl);
		logic [1:0] m;
		m = (c == drive_sup_pkg::CONTROL_VECTOR_SENSOR) ? w : v;
		return frc || m == drive_sup_pkg::MODE_BOTH || (pl && m == drive_sup_pkg::MODE_POWER_LOSS);
	endfunction : want
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge mclk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do begin
			@(posedge mclk_i);
			k++;
		end while (wb_ack_o !== 1'h1 && k < 20);
		r = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		if (k >= 20) err_total++;
	endtask : wb
	task automatic wait_rst(input int lim_n, output int m);
		m = 0;
		do begin
			@(negedge mclk_i);
			m++;
		end while (trip_reset_o !== 1'h1 && alarm_out_o !== 1'h1 && m < lim_n);
	endtask : wait_rst
	// The trip is held, so each reset command meets a fault still present and counts as a new trip.
	task automatic trip_run(input logic [3:0] c, output int pc);
		int m;
		pc = 0;
		@(posedge mclk_i);
		trip_i <= 1'h1;
		trip_cause_i <= c;
		do begin
			wait_rst(300, m);
			if (trip_reset_o === 1'h1) begin
				pc++;
				`CHK("gap", 1'h1, 1'(m >= (iv - 1) * TK && m <= (iv + 1) * TK + 6))
			end
		end while (trip_reset_o === 1'h1);
		@(posedge mclk_i);
		trip_i <= 1'h0;
	endtask : trip_run
	task automatic clear_alarm();
		wb(1'h1, drive_sup_pkg::ADR_CMD, 32'h1, q);
		@(posedge mclk_i);
		`CHK("alarm clear", 1'h0, alarm_out_o)
	endtask : clear_alarm
	task automatic complete_run();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	// ****************
	// Sequence
	// ****************
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		repeat (99000) @(posedge mclk_i);
		err_total++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge mclk_i);
		srst_i <= 1'h0;
		wb(1'h0, A_CT, 32'h0, q);
		`CHK("ctrl", 32'h00004000, q)
		wb(1'h0, A_TM, 32'h0, q);
		`CHK("time", 32'h00010005, q)
		wb(1'h1, 8'h10, 32'h5a5a5a5a, q);
		wb(1'h0, 8'h10, 32'h0, q);
		`CHK("unmapped", 32'h0, q)
		`CHK("fan", 2'h2, {fan_on_o, fan_running_out_o})
		wb(1'h1, A_CT, ctrl(4'hf, 1'h0, 2'h0, 1'h0, 3'h0, 2'h0, 2'h0), q);
		wb(1'h0, A_CT, 32'h0, q);
		`CHK("limit", drive_sup_pkg::RETRY_LIMIT_MAX, q[3:0])
		fwd_cmd_i <= 1'h1;
		rev_cmd_i <= 1'h1;
		for (int d = 0; d < 3; d++) begin
			wb(1'h1, A_CT, ctrl(4'h0, 1'h0, 2'(d), 1'h0, 3'h0, 2'h0, 2'h0), q);
			repeat (3) @(posedge mclk_i);
			`CHK("fwd", 1'(d != 2), fwd_run_o)
			`CHK("rev", 1'(d != 1), rev_run_o)
		end
		fwd_cmd_i <= 1'h0;
		rev_cmd_i <= 1'h0;
		iv = 5 + roll(8);
		wb(1'h1, A_TM, {8'h0, 8'h01, 8'h03, 8'(iv)}, q);
		for (int c = 0; c < 16; c++) begin
			lim = roll(11);
			wb(1'h1, A_CT, ctrl(4'(lim), 1'h0, 2'h0, 1'h0, 3'h0, 2'h0, 2'h0), q);
			trip_run(4'(c), p);
			`CHK("retries", (c >= 1 && c <= 8) ? lim : 0, p)
			`CHK("alarm", 1'h1, alarm_out_o)
			wb(1'h0, drive_sup_pkg::ADR_STATUS, 32'h0, q);
			`CHK("status alarm", 1'h1, q[0])
			clear_alarm();
		end
		wb(1'h1, A_CT, ctrl(4'h2, 1'h0, 2'h0, 1'h0, 3'h0, 2'h0, 2'h0), q);
		@(posedge mclk_i);
		trip_i <= 1'h1;
		trip_cause_i <= 4'h1;
		wait_rst(300, n);
		@(posedge mclk_i);
		trip_i <= 1'h0;
		wait_rst(300, n);
		@(posedge mclk_i);
		drive_running_i <= 1'h1;
		repeat (4) @(posedge mclk_i);
		`CHK("retry active", 1'h0, retry_active_out_o)
		drive_running_i <= 1'h0;
		trip_run(4'h2, p);
		`CHK("fresh retries", 2, p)
		clear_alarm();
		for (int k = 0; k < 32; k++) begin
			s = k[3] ? drive_sup_pkg::CONTROL_VECTOR_SENSOR : 3'(roll(3));
			mv = 2'(roll(3));
			mc = 2'(roll(3));
			wb(1'h1, A_CT, ctrl(4'h0, 1'h0, 2'h0, k[2], s, mv, mc), q);
			search_force_in_i <= k[1];
			coast_stop_in_i <= k[0] & k[4];
			stop_i <= 1'h1;
			repeat (4) @(posedge mclk_i);
			stop_i <= 1'h0;
			coast_stop_in_i <= 1'h0;
			if (k[0] && !k[4]) power_restart_i <= 1'h1;
			else if (!k[0]) run_start_i <= 1'h1;
			@(posedge mclk_i);
			power_restart_i <= 1'h0;
			run_start_i <= 1'h0;
			at = -1;
			len = 0;
			n = 0;
			do begin
				@(negedge mclk_i);
				n++;
				if (search_active_o === 1'h1 && at < 0) at = n;
				if (search_active_o === 1'h1) len++;
			end while (accel_start_o !== 1'h1 && n < 600);
			`CHK("accel", 1'h1, accel_start_o)
			`CHK("search", want(s, mv, mc, k[1] && k[2], k[0] && !k[4]), 1'(at >= 0))
			dl = k[0] ? 1 : 3;
			if (at >= 0) `CHK("delay", 1'h1, 1'(at >= (dl - 1) * TK && at <= (dl + 1) * TK + 6))
			if (at >= 0) `CHK("length", 1'h1, 1'(len >= 11 * TK && len <= 13 * TK + 4))
		end
		wb(1'h1, A_CT, ctrl(4'h0, 1'h1, 2'h0, 1'h0, 3'h0, 2'h0, 2'h0), q);
		repeat (3) @(posedge mclk_i);
		`CHK("fan flag", 1'h1, fan_running_out_o)
		temp_low_i <= 1'h1;
		n = 0;
		do begin
			@(negedge mclk_i);
			n++;
		end while (fan_on_o !== 1'h0 && n < 61000);
		@(posedge mclk_i);
		`CHK("fan stop", 2'h0, {fan_on_o, fan_running_out_o})
		drive_running_i <= 1'h1;
		repeat (3) @(posedge mclk_i);
		`CHK("fan run", 1'h1, fan_on_o)
		complete_run();
	end
endmodule : tb
bind drive_supervisor drive_sup_asserts #(.TICK_CYCLES(TICK_CYCLES)) drive_sup_asserts_i (.mclk_i, .srst_i,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .fwd_cmd_i, .rev_cmd_i, .alarm_out_o, .retry_active_out_o,
	.trip_reset_o, .fan_on_o, .fan_running_out_o, .fwd_run_o, .rev_run_o, .search_active_o);
